// File: rtl/ch1_irq_pkg.sv
/*
  constants, field layouts and carrier types for the channel 1 serial
  interrupt flag logic and its port 2 pin multiplexer.
  assumes a single processor clock domain; no register bus reaches it.
*/
// Overview of operation
// R01: completions set receive or transmit done flags
// R02: irq output is OR of both flags
// R03: software write setting a flag raises irq
// R04: irq drops only when flags clear; read clears
// R05: irq goes to pin, not interrupt controller
// R06: irq pin reached only via port 2 mux
// R07: board ties irq pin to external interrupt
// R08: channel 1 and ch0 baud clock share port 2
// R09: synchronous receive enable shifts byte, sets flag
// R10: done at stop middle or eighth bit middle
// R11: flags registered, irq combinational from flags
package ch1_irq_pkg;

  // port 2 geometry
  localparam int unsigned PORT2_WIDTH     = 8;
  // port 2 pin positions of the shared serial functions
  localparam int unsigned PIN_RECEIVE     = 0;
  localparam int unsigned PIN_TRANSMIT    = 1;
  localparam int unsigned PIN_BAUD0       = 2;
  localparam int unsigned PIN_IRQ         = 3;

  // receive byte geometry
  localparam int unsigned BYTE_BITS       = 8;
  localparam logic [2:0]  LAST_BIT_INDEX  = 3'h7;
  localparam logic [2:0]  BIT_COUNT_RESET = 3'h0;
  localparam logic [7:0]  BYTE_RESET      = 8'h00;

  // input synchroniser depth
  localparam int unsigned SYNC_STAGES     = 3;

  // status flag layout and reset values
  localparam int unsigned RX_DONE_POS     = 0;
  localparam int unsigned TX_DONE_POS     = 1;
  localparam logic        FLAG_RESET      = 1'b0;
  localparam logic        PIN_IDLE_LEVEL  = 1'b1;

  // channel 1 status flags
  typedef struct packed {
    logic transmit_done_flag;
    logic receive_done_flag;
  } ch1_status_register_t;

  localparam ch1_status_register_t STATUS_RESET = '{FLAG_RESET, FLAG_RESET};

  // synchronous receive sequencer, gray along idle -> shift -> done
  typedef enum logic [1:0] {
    RX_IDLE  = 2'h0,
    RX_SHIFT = 2'h1,
    RX_HELD  = 2'h3
  } rx_state_t;

  // port 2 pin group
  typedef struct packed {
    logic [PORT2_WIDTH-1:0] level;
    logic [PORT2_WIDTH-1:0] enable;
  } port2_drive_t;

endpackage : ch1_irq_pkg

// File: rtl/port2_pin_mux.sv
/*
  port 2 output multiplexer: each pin shows either its port latch or the
  serial function assigned to it.
  assumes the serial functions and port latch sit on the same clock.
*/
`timescale 1ns/100ps
module port2_pin_mux
  import ch1_irq_pkg::*;
(
  // selection and port latch
  input  wire logic [PORT2_WIDTH-1:0] serial_sel,
  input  wire logic [PORT2_WIDTH-1:0] port_latch,
  // serial functions per pin
  input  wire logic [PORT2_WIDTH-1:0] func_level,
  input  wire logic [PORT2_WIDTH-1:0] func_enable,
  // resulting pin drive
  output port2_drive_t                pin_drive
);

  // per pin choice between port latch and serial function
  genvar gi;
  generate
    for (gi = 0; gi < PORT2_WIDTH; gi++) begin : g_pin
      // port latch always drives; serial function uses its own enable
      assign pin_drive.level[gi]  = serial_sel[gi] ? func_level[gi]  : port_latch[gi]; // R08
      assign pin_drive.enable[gi] = serial_sel[gi] ? func_enable[gi] : 1'b1;           // R08
    end
  endgenerate

endmodule : port2_pin_mux

// File: rtl/serial_ch1_irq_flag_logic.sv
/*
  channel 1 serial interrupt flags, request line, synchronous receive
  polling path and port 2 pin routing.
  assumes completion pulses and bit ticks come from channel logic on
  sys_clk; the receive pin input arrives asynchronously and is synchronised here.
*/
`timescale 1ns/100ps
module serial_ch1_irq_flag_logic
  import ch1_irq_pkg::*;
(
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  // completion pulses from the frame machines (stop bit middle)
  input  wire logic                   async_rx_complete,
  input  wire logic                   tx_complete,
  // synchronous receive control
  input  wire logic                   sync_mode,
  input  wire logic                   rx_enable,
  input  wire logic                   sync_bit_tick,
  // status access by software
  input  wire logic                   status_rd,
  input  wire logic                   status_wr,
  input  wire ch1_status_register_t   status_wdata,
  output ch1_status_register_t        status_rdata,
  // received byte
  output logic [BYTE_BITS-1:0]        receive_holding_buffer,
  output logic                        rx_busy,
  // request line, internal view
  output logic                        ch1_serial_irq,
  // serial functions toward the pins
  input  wire logic                   ch1_transmit_pin,
  input  wire logic                   ch1_transmit_oe,
  output logic                        ch0_baud_ext_clock,
  // port 2 pins
  input  wire logic [PORT2_WIDTH-1:0] port2_serial_sel,
  input  wire logic [PORT2_WIDTH-1:0] port2_latch,
  input  wire logic [PORT2_WIDTH-1:0] port2_pin_i,
  output logic [PORT2_WIDTH-1:0]      port2_pin_o,
  output logic [PORT2_WIDTH-1:0]      port2_pin_oe
);

  // status flags
  ch1_status_register_t       status_q;       // sticky flags
  ch1_status_register_t       status_d;       // next flags
  // receive pin synchroniser
  logic [SYNC_STAGES-1:0]     rx_sync_q;      // shift chain
  logic                       rx_level_q;     // filtered level
  // synchronous receive sequencer
  rx_state_t                  rx_state_q;     // sequencer state
  rx_state_t                  rx_state_d;     // next state
  logic [2:0]                 bit_index_q;    // bits taken so far
  logic [BYTE_BITS-1:0]       shift_q;        // assembling byte
  logic                       sync_rx_done;   // eighth bit sampled
  logic                       take_bit;       // sample strobe
  // pin mux signals
  logic [PORT2_WIDTH-1:0]     func_level;     // serial function levels
  logic [PORT2_WIDTH-1:0]     func_enable;    // serial function enables
  port2_drive_t               pin_drive;      // mux result
  logic                       rx_pin_routed;  // receive pin seen via mux

  // flag decode used by the request line
  function automatic logic any_flag(input ch1_status_register_t s);
    any_flag = s.receive_done_flag | s.transmit_done_flag;
  endfunction : any_flag

  // receive pin only reaches the channel while the mux selects it
  assign rx_pin_routed = port2_serial_sel[PIN_RECEIVE] ?
                         port2_pin_i[PIN_RECEIVE] : PIN_IDLE_LEVEL; // R08

  // three stage chain for the asynchronous receive pin
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_sync_q <= {SYNC_STAGES{PIN_IDLE_LEVEL}};
    end else begin
      rx_sync_q <= {rx_sync_q[SYNC_STAGES-2:0], rx_pin_routed};
    end
  end

  // level accepted only once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_level_q <= PIN_IDLE_LEVEL;
    end else if (rx_sync_q[1] == rx_sync_q[2]) begin
      rx_level_q <= rx_sync_q[2];
    end
  end

  // bit strobe while shifting
  assign take_bit     = (rx_state_q == RX_SHIFT) && sync_bit_tick;
  // eighth bit middle completes the byte
  assign sync_rx_done = take_bit && (bit_index_q == LAST_BIT_INDEX); // R10

  // sequencer next state
  always_comb begin
    rx_state_d = rx_state_q;
    unique case (rx_state_q)
      // idle: enable in synchronous mode starts shifting
      RX_IDLE: begin
        if (sync_mode && rx_enable) begin
          rx_state_d = RX_SHIFT; // R09
        end
      end
      // shift: dropping enable abandons the byte
      RX_SHIFT: begin
        if (!sync_mode || !rx_enable) begin
          rx_state_d = RX_IDLE;
        end else if (sync_rx_done) begin
          rx_state_d = RX_HELD;
        end
      end
      // held: wait for enable to be released before rearming
      RX_HELD: begin
        if (!sync_mode || !rx_enable) begin
          rx_state_d = RX_IDLE;
        end
      end
      // illegal code returns to idle
      default: begin
        rx_state_d = RX_IDLE;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state_q <= RX_IDLE;
    end else begin
      rx_state_q <= rx_state_d;
    end
  end

  // bit counter and shifter, lsb first
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_index_q <= BIT_COUNT_RESET;
      shift_q     <= BYTE_RESET;
    end else if (rx_state_q != RX_SHIFT) begin
      bit_index_q <= BIT_COUNT_RESET;
    end else if (take_bit) begin
      bit_index_q <= bit_index_q + 3'h1;
      shift_q     <= {rx_level_q, shift_q[BYTE_BITS-1:1]}; // R09
    end
  end

  // completed byte lands in the holding buffer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      receive_holding_buffer <= BYTE_RESET;
    end else if (sync_rx_done) begin
      receive_holding_buffer <= {rx_level_q, shift_q[BYTE_BITS-1:1]}; // R09
    end
  end

  // busy while a synchronous byte is in flight
  assign rx_busy = (rx_state_q == RX_SHIFT);

  // flag next value: read clears, write loads, hardware set wins last
  always_comb begin
    status_d = status_q;
    if (status_rd) begin
      status_d = STATUS_RESET; // R04
    end
    if (status_wr) begin
      status_d = status_wdata; // R03
    end
    if (async_rx_complete || sync_rx_done) begin
      status_d.receive_done_flag = 1'b1; // R01 R09
    end
    if (tx_complete) begin
      status_d.transmit_done_flag = 1'b1; // R01
    end
  end

  // sticky flags on the processor clock
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= status_d; // R11
    end
  end

  // read data shows the flags as held before any clear
  assign status_rdata = status_q;

  // request line is a plain or of the held flags, no extra stage
  assign ch1_serial_irq = any_flag(status_q); // R02 R11

  // serial function map onto port 2 pins
  always_comb begin
    func_level                = port2_latch;
    func_enable               = '0;
    func_level[PIN_TRANSMIT]  = ch1_transmit_pin;
    func_enable[PIN_TRANSMIT] = ch1_transmit_oe;
    // request line leaves on a pin rather than the interrupt controller
    func_level[PIN_IRQ]       = ch1_serial_irq; // R05
    func_enable[PIN_IRQ]      = 1'b1;           // R06
  end

  // shared pin multiplexer
  port2_pin_mux u_port2_pin_mux (
    .serial_sel  (port2_serial_sel),
    .port_latch  (port2_latch),
    .func_level  (func_level),
    .func_enable (func_enable),
    .pin_drive   (pin_drive)
  );

  // pin outputs; receive and baud pins are inputs while serial selected
  always_comb begin
    port2_pin_o  = pin_drive.level;
    port2_pin_oe = pin_drive.enable;
    if (port2_serial_sel[PIN_RECEIVE]) begin
      port2_pin_oe[PIN_RECEIVE] = 1'b0; // R08
    end
    if (port2_serial_sel[PIN_BAUD0]) begin
      port2_pin_oe[PIN_BAUD0] = 1'b0; // R08
    end
  end

  // external baud clock for channel 0 only via the selected pin
  assign ch0_baud_ext_clock = port2_serial_sel[PIN_BAUD0] & port2_pin_i[PIN_BAUD0]; // R08

endmodule : serial_ch1_irq_flag_logic

// File: verification/ch1_irq_sva.sv
/* assertions on the channel 1 flag logic top ports.
   assumes one clock, sys_clk, and the active low rst_b. */
`timescale 1ns/100ps
module ch1_irq_sva
  import ch1_irq_pkg::*;
(
  // clock and reset
  input wire logic                   sys_clk,
  input wire logic                   rst_b,
  // events and status access
  input wire logic                   async_rx_complete,
  input wire logic                   tx_complete,
  input wire logic                   sync_mode,
  input wire logic                   rx_enable,
  input wire logic                   status_rd,
  input wire logic                   status_wr,
  input wire ch1_status_register_t   status_wdata,
  input wire ch1_status_register_t   status_rdata,
  input wire logic                   rx_busy,
  input wire logic                   ch1_serial_irq,
  // pins
  input wire logic                   ch0_baud_ext_clock,
  input wire logic [PORT2_WIDTH-1:0] port2_serial_sel,
  input wire logic [PORT2_WIDTH-1:0] port2_pin_i,
  input wire logic [PORT2_WIDTH-1:0] port2_pin_o,
  input wire logic [PORT2_WIDTH-1:0] port2_pin_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // no flag source active this cycle
  logic quiet;
  assign quiet = !tx_complete && !async_rx_complete && !rx_busy;
  // sync receive steps: arming, then end of a byte
  sequence s_arm; !rx_busy ##1 rx_busy; endsequence
  sequence s_end; rx_busy && sync_mode && rx_enable ##1 !rx_busy; endsequence
  a_irq_or_flags: assert property (ch1_serial_irq == |status_rdata)
    else $error("irq is not the or of the flags");
  a_tx_sets_flag: assert property (tx_complete |=> status_rdata.transmit_done_flag)
    else $error("transmit completion left its flag clear");
  a_rx_sets_flag: assert property (async_rx_complete |=> status_rdata.receive_done_flag)
    else $error("receive completion left its flag clear");
  a_read_clears: assert property (status_rd && !status_wr && quiet |=> status_rdata == '0)
    else $error("status read did not clear the flags");
  a_write_loads: assert property (status_wr && quiet |=> status_rdata == $past(status_wdata))
    else $error("status write did not load the flags");
  a_irq_on_pin: assert property (port2_serial_sel[PIN_IRQ] |->
    port2_pin_o[PIN_IRQ] == ch1_serial_irq && port2_pin_oe[PIN_IRQ])
    else $error("request pin does not show the irq");
  a_baud_input: assert property (ch0_baud_ext_clock ==
    (port2_serial_sel[PIN_BAUD0] && port2_pin_i[PIN_BAUD0]))
    else $error("baud clock input routing wrong");
  a_rx_pin_input: assert property (port2_serial_sel[PIN_RECEIVE] |->
    !port2_pin_oe[PIN_RECEIVE])
    else $error("receive pin driven while serial selected");
  a_rx_arm: assert property (s_arm |-> $past(sync_mode && rx_enable))
    else $error("receive started without enable");
  a_rx_done: assert property (s_end |-> status_rdata.receive_done_flag)
    else $error("byte ended without receive flag");
endmodule : ch1_irq_sva
bind serial_ch1_irq_flag_logic ch1_irq_sva chk (.*);

// File: verification/ext_irq_input_model.sv
/* external interrupt input fed by the request pin.
   assumes the processor samples the pin on sys_clk; undriven reads low. */
`timescale 1ns/100ps
module ext_irq_input_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // request pin and its enable
  input wire logic pin,
  input wire logic pin_oe,
  // requests taken
  output int       edges
);
  logic level_q; // last sampled level
  // one request per rising level on the wired pin
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      level_q <= 1'b0;
      edges   <= 0;
    end else begin
      level_q <= pin && pin_oe;
      if (pin && pin_oe && !level_q) edges <= edges + 1;
    end
  end
endmodule : ext_irq_input_model

// File: verification/serial_ch1_irq_flag_logic_tb.sv
/* self-checking bench for the channel 1 flag logic.
   assumes the checker is bound and the pin model sits on pin 3. */
`timescale 1ns/100ps
module serial_ch1_irq_flag_logic_tb;
  import ch1_irq_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic async_rx_complete, tx_complete, sync_mode, rx_enable, sync_bit_tick;
  logic status_rd, status_wr, rx_busy, ch1_serial_irq, ch0_baud_ext_clock;
  logic ch1_transmit_pin, ch1_transmit_oe;
  ch1_status_register_t status_wdata, status_rdata;
  logic [BYTE_BITS-1:0] receive_holding_buffer;
  logic [PORT2_WIDTH-1:0] port2_serial_sel, port2_latch, port2_pin_i, port2_pin_o, port2_pin_oe;
  int failures = 0;
  int n_checks = 0;
  int irq_edges;
  always #2 sys_clk = ~sys_clk;
  serial_ch1_irq_flag_logic dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .async_rx_complete(async_rx_complete), .tx_complete(tx_complete),
    .sync_mode(sync_mode), .rx_enable(rx_enable), .sync_bit_tick(sync_bit_tick),
    .status_rd(status_rd), .status_wr(status_wr), .status_wdata(status_wdata),
    .status_rdata(status_rdata), .receive_holding_buffer(receive_holding_buffer),
    .rx_busy(rx_busy), .ch1_serial_irq(ch1_serial_irq), .ch1_transmit_pin(ch1_transmit_pin),
    .ch1_transmit_oe(ch1_transmit_oe), .ch0_baud_ext_clock(ch0_baud_ext_clock),
    .port2_serial_sel(port2_serial_sel), .port2_latch(port2_latch),
    .port2_pin_i(port2_pin_i), .port2_pin_o(port2_pin_o), .port2_pin_oe(port2_pin_oe));
  ext_irq_input_model partner (.sys_clk(sys_clk), .rst_b(rst_b), .pin(port2_pin_o[PIN_IRQ]),
    .pin_oe(port2_pin_oe[PIN_IRQ]), .edges(irq_edges));
  // step to the next falling edge n times
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  // compare one bit
  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  // compare a byte wide value
  task automatic chk_vec(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_vec
  // completion pulse, sticky flag, read clears
  task automatic t_completion(input logic is_tx);
    tx_complete = is_tx;
    async_rx_complete = !is_tx;
    tick(1);
    tx_complete = 1'b0;
    async_rx_complete = 1'b0;
    chk_vec("flag set", is_tx ? 8'h02 : 8'h01, {6'h00, status_rdata});
    tick(3);
    chk_bit("irq holds", 1'b1, ch1_serial_irq);
    status_rd = 1'b1;
    tick(1);
    status_rd = 1'b0;
    chk_vec("flags read", 8'h00, {6'h00, status_rdata});
    chk_bit("irq read", 1'b0, ch1_serial_irq);
  endtask : t_completion
  // software writes, then a read meeting a completion
  task automatic t_sw_write;
    for (int v = 1; v < 4; v++) begin
      status_wdata = ch1_status_register_t'(v[1:0]);
      status_wr = 1'b1;
      tick(1);
      status_wr = 1'b0;
      chk_vec("written", v[7:0], {6'h00, status_rdata});
      chk_bit("irq written", 1'b1, ch1_serial_irq);
      tick(1);
    end
    status_wdata = STATUS_RESET;
    status_rd = 1'b1;
    tx_complete = 1'b1;
    tick(1);
    status_rd = 1'b0;
    tx_complete = 1'b0;
    chk_vec("event beats read", 8'h02, {6'h00, status_rdata});
    status_wr = 1'b1;
    tick(1);
    status_wr = 1'b0;
    chk_bit("irq cleared", 1'b0, ch1_serial_irq);
  endtask : t_sw_write
  // port 2 routing and the wired interrupt input
  task automatic t_pins;
    port2_latch = 8'hC3;
    tick(1);
    chk_vec("latch out", 8'hC3, port2_pin_o);
    chk_vec("pin enables", 8'hFF, port2_pin_oe);
    chk_bit("baud off", 1'b0, ch0_baud_ext_clock);
    port2_serial_sel = 8'h0E;
    ch1_transmit_pin = 1'b1;
    ch1_transmit_oe = 1'b0;
    tx_complete = 1'b1;
    tick(1);
    tx_complete = 1'b0;
    tick(2);
    chk_vec("serial enables", 8'hF9, port2_pin_oe);
    chk_bit("tx pin", 1'b1, port2_pin_o[PIN_TRANSMIT]);
    chk_bit("baud in", 1'b1, ch0_baud_ext_clock);
    chk_bit("irq pin", 1'b1, port2_pin_o[PIN_IRQ]);
    chk_vec("requests taken", 8'h01, irq_edges[7:0]);
    status_rd = 1'b1;
    tick(1);
    status_rd = 1'b0;
    chk_bit("irq pin low", 1'b0, port2_pin_o[PIN_IRQ]);
  endtask : t_pins
  // synchronous byte, lsb first, polled flag
  task automatic t_sync_rx(input logic [7:0] b);
    port2_serial_sel = 8'h09;
    sync_mode = 1'b1;
    rx_enable = 1'b1;
    tick(1);
    chk_bit("shifting", 1'b1, rx_busy);
    for (int i = 0; i < 8; i++) begin
      port2_pin_i[PIN_RECEIVE] = b[i];
      tick(6);
      sync_bit_tick = 1'b1;
      tick(1);
      sync_bit_tick = 1'b0;
    end
    for (int i = 0; i < 4 && status_rdata.receive_done_flag !== 1'b1; i++) tick(1);
    chk_bit("rx flag", 1'b1, status_rdata.receive_done_flag);
    if (failures != 0) end_of_test();
    chk_vec("byte", b, receive_holding_buffer);
    chk_bit("done idle", 1'b0, rx_busy);
    rx_enable = 1'b0;
    sync_mode = 1'b0;
    status_rd = 1'b1;
    tick(1);
    status_rd = 1'b0;
  endtask : t_sync_rx
  // counts, verdict, stop
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial begin
    {async_rx_complete, tx_complete, sync_mode, rx_enable, sync_bit_tick} = '0;
    {status_rd, status_wr} = '0;
    {ch1_transmit_pin, ch1_transmit_oe} = 2'b01;
    status_wdata = STATUS_RESET;
    port2_serial_sel = '0;
    port2_latch = '0;
    port2_pin_i = '1;
    tick(3);
    rst_b = 1'b1;
    chk_vec("reset flags", 8'h00, {6'h00, status_rdata});
    t_completion(1'b1);
    t_completion(1'b0);
    t_sw_write();
    t_pins();
    t_sync_rx(8'hA5);
    t_sync_rx(8'h3C);
    end_of_test();
  end
endmodule : serial_ch1_irq_flag_logic_tb
